// File: verilog/dms_pkg.sv
// Constants and types shared by the decimal multiply sequencer.
package dms_pkg;
  localparam int DIGITS        = 10;
  localparam int ACC_COLS      = 20;
  localparam int ACC_CYCLE_MS  = 200;
  localparam int MAIN_CYCLE_MS = 550;
  localparam int CLK_MHZ       = 250;
  localparam int ACC_CYCLE_CLKS  = ACC_CYCLE_MS * 1000 * CLK_MHZ;
  localparam int MAIN_CYCLE_CLKS = MAIN_CYCLE_MS * 1000 * CLK_MHZ;
  localparam int ROUND_CYCLES  = 2;
  localparam logic [3:0] SHIFT_2 = 4'h2;
  localparam logic [3:0] SHIFT_5 = 4'h5;
  localparam logic [3:0] SHIFT_7 = 4'h7;
  localparam logic [3:0] SHIFT_8 = 4'h8;
  localparam logic [4:0] LOW_COL_S8 = 5'h00;
  localparam logic [4:0] LOW_COL_S7 = 5'h01;
  localparam logic [4:0] LOW_COL_S5 = 5'h03;
  localparam logic [4:0] LOW_COL_S2 = 5'h06;
  localparam logic [3:0] DIGIT_ZERO = 4'h0;

  typedef enum logic [6:0] {
    DMS_IDLE  = 7'b0000001,
    DMS_SCAN  = 7'b0000010,
    DMS_RIGHT = 7'b0000100,
    DMS_LEFT  = 7'b0001000,
    DMS_ROUND = 7'b0010000,
    DMS_MAIN  = 7'b0100000,
    DMS_DONE  = 7'b1000000
  } dms_state_t;
endpackage

// File: verilog/dms_slot_timer.sv
// Fixed-length time slot counter used for accumulator and main cycles.
module dms_slot_timer #(
  parameter int CW = 32
) (
  input  wire logic          clk,
  input  wire logic          rst_n,
  input  wire logic          start,
  input  wire logic [CW-1:0] length,
  output logic               last
);
  logic [CW-1:0] count;

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      count <= '0;
    else if (start)
      count <= length;
    else if (count != '0)
      count <= count - 1'b1;
  end

  // A slot begins on the clock after start, when the new state is entered,
  // so a slot of length L covers exactly L cycles of that state.
  assign last = (count == CW'(1));
endmodule // dms_slot_timer

// File: verilog/dms_sequencer.sv
// Decimal multiply sequencer with column select and product cycle control.
// Overview of operation
// - Each nonzero multiplier digit takes exactly two accumulator cycles.
// - First cycle adds right-hand components, second adds left-hand ones.
// - Multiply cycles never overlap the main machine cycle.
// - Each accumulator cycle is one fixed 200 ms slot.
// - Nonzero digit takes 400 ms; zero digit costs no accumulator cycle.
// - Time depends only on nonzero multiplier digits and round-off, not the multiplicand.
// - Programmed round-off and clear adds two more accumulator cycles.
// - One 550 ms main cycle ends the operation and transfers the product.
// - Order: operands loaded, shift applied, accumulate, then round-off.
// - Product is read out and cleared on the following main cycle.
// - A loaded multiplier is kept for later constant-factor problems.
// - Shift column selection is latched before accumulation and held.
// - Only shifts 2, 5, 7 and 8 are accepted.
// - Twenty columns; shift 7 skips lowest, shift 5 skips three lowest.
// - Left-hand components land one column left of right-hand ones.
// - Digits run from least significant, one position left each time.
// - Loading an operand replaces its whole store with the new value in one clock.
module dms_sequencer
  import dms_pkg::*;
#(
  parameter int ND         = DIGITS,
  parameter int ACC_CLKS   = ACC_CYCLE_CLKS,
  parameter int MAIN_CLKS  = MAIN_CYCLE_CLKS
) (
  input  wire logic          clk,
  input  wire logic          rst_n,
  input  wire logic          multiplier_load,
  input  wire logic          multiplicand_load,
  input  wire logic [4*ND-1:0] operand_in,
  input  wire logic          multiply_arm,
  input  wire logic          multiply_go,
  input  wire logic [3:0]    shift_sel,
  input  wire logic          round_clear,
  output logic               busy,
  output logic               shift_error,
  output logic               acc_add,
  output logic               acc_left,
  output logic [3:0]         acc_digit,
  output logic [4:0]         acc_column,
  output logic               acc_round,
  output logic               main_cycle,
  output logic               product_transfer,
  output logic [4*ND-1:0]    multiplier_value,
  output logic [4*ND-1:0]    multiplicand_value
);
  dms_state_t state;
  logic        armed;
  logic [4:0]  low_col;
  logic [$clog2(ND+1)-1:0] pos;
  logic        rc_latched;
  logic        round_n;
  logic        slot_start;
  logic [31:0] slot_len;
  logic        slot_last;
  logic        shift_ok;
  logic [3:0]  cur_digit;
  logic [31:0] right_len;

  assign shift_ok = (shift_sel == SHIFT_2) || (shift_sel == SHIFT_5) ||
                    (shift_sel == SHIFT_7) || (shift_sel == SHIFT_8);
  assign cur_digit = (pos < ND) ? multiplier_value[4*pos +: 4] : DIGIT_ZERO;

  // Operands change only while idle; a load replaces the whole store.
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      multiplier_value <= '0;
    else if (state == DMS_IDLE && multiplier_load)
      multiplier_value <= operand_in;
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      multiplicand_value <= '0;
    else if (state == DMS_IDLE && multiplicand_load)
      multiplicand_value <= operand_in;
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      armed <= 1'b0;
    else if (state == DMS_IDLE && multiply_arm)
      armed <= 1'b1;
    else if (state == DMS_SCAN)
      armed <= 1'b0;
  end

  // Error flag holds until a good shift starts a multiply.
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      shift_error <= 1'b0;
    else if (state == DMS_IDLE && multiply_go && armed)
      shift_error <= !shift_ok;
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      low_col    <= LOW_COL_S8;
      rc_latched <= 1'b0;
    end
    else if (state == DMS_IDLE && multiply_go && armed && shift_ok)
    begin
      rc_latched <= round_clear;
      unique case (shift_sel)
        SHIFT_8: low_col <= LOW_COL_S8;
        SHIFT_7: low_col <= LOW_COL_S7;
        SHIFT_5: low_col <= LOW_COL_S5;
        default: low_col <= LOW_COL_S2;
      endcase
    end
  end

  // Zero digits are skipped in the scan state at one clock per digit, which
  // is negligible against a 200 ms slot.
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state   <= DMS_IDLE;
      pos     <= '0;
      round_n <= 1'b0;
    end
    else
    begin
      unique case (state)
        DMS_IDLE:
          if (multiply_go && armed && shift_ok)
          begin
            state <= DMS_SCAN;
            pos   <= '0;
          end
        DMS_SCAN:
          if (pos >= ND)
          begin
            state   <= rc_latched ? DMS_ROUND : DMS_MAIN;
            round_n <= 1'b0;
          end
          else if (cur_digit == DIGIT_ZERO)
            pos <= pos + 1'b1;
          else
            state <= DMS_RIGHT;
        DMS_RIGHT:
          if (slot_last)
            state <= DMS_LEFT;
        DMS_LEFT:
          if (slot_last)
          begin
            state <= DMS_SCAN;
            pos   <= pos + 1'b1;
          end
        DMS_ROUND:
          if (slot_last)
          begin
            round_n <= 1'b1;
            if (round_n)
              state <= DMS_MAIN;
          end
        DMS_MAIN:
          if (slot_last)
            state <= DMS_DONE;
        DMS_DONE:
          state <= DMS_IDLE;
      endcase
    end
  end

  assign slot_start = (state == DMS_SCAN) ||
                      ((state != DMS_MAIN) && slot_last) ||
                      (state == DMS_IDLE);
  assign slot_len = (state == DMS_ROUND && round_n) || (state == DMS_SCAN && pos >= ND &&
                    !rc_latched) ? 32'(MAIN_CLKS) : 32'(ACC_CLKS);

  dms_slot_timer #(.CW(32)) u_slot (
    .clk    (clk),
    .rst_n  (rst_n),
    .start  (slot_start),
    .length (slot_len),
    .last   (slot_last)
  );

  assign busy       = (state != DMS_IDLE);
  assign acc_add    = (state == DMS_RIGHT) || (state == DMS_LEFT);
  assign acc_left   = (state == DMS_LEFT);
  assign acc_round  = (state == DMS_ROUND);
  assign main_cycle = (state == DMS_MAIN);

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      acc_digit        <= DIGIT_ZERO;
      acc_column       <= LOW_COL_S8;
      product_transfer <= 1'b0;
    end
    else
    begin
      acc_digit        <= cur_digit;
      acc_column       <= low_col + 5'(pos) + ((state == DMS_LEFT) ? 5'h01 : 5'h00);
      product_transfer <= (state == DMS_MAIN) && slot_last;
    end
  end

  // Counts the clocks already spent in the current right-hand slot.
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      right_len <= '0;
    else
      right_len <= (state == DMS_RIGHT) ? right_len + 32'h1 : '0;
  end

  a_right_len: assert property (@(posedge clk) disable iff (!rst_n)
    (state == DMS_LEFT && $past(state) == DMS_RIGHT) |-> $past(right_len) == 32'(ACC_CLKS - 1))
    else $error("right-hand slot length wrong");

  a_add_excl_main: assert property (@(posedge clk) disable iff (!rst_n)
    !(acc_add && main_cycle)) else $error("accumulator add overlaps main cycle");

  sequence s_right_then_left;
    (state == DMS_RIGHT) ##1 (state == DMS_LEFT);
  endsequence
  a_right_before_left: assert property (@(posedge clk) disable iff (!rst_n)
    (state == DMS_LEFT && $past(state) != DMS_LEFT) |-> $past(state) == DMS_RIGHT)
    else $error("left cycle not preceded by right cycle");
  a_digit_two_cyc: assert property (@(posedge clk) disable iff (!rst_n)
    s_right_then_left |-> ##1 (state == DMS_LEFT || state == DMS_SCAN))
    else $error("digit cycle order broken");
  a_zero_skipped: assert property (@(posedge clk) disable iff (!rst_n)
    (state == DMS_SCAN && pos < ND && cur_digit == DIGIT_ZERO) |=> state == DMS_SCAN)
    else $error("zero digit consumed a cycle");
  a_shift_held: assert property (@(posedge clk) disable iff (!rst_n)
    (busy && $past(busy)) |-> $stable(low_col))
    else $error("shift selection changed mid operation");
  a_shift_legal: assert property (@(posedge clk) disable iff (!rst_n)
    ($rose(busy)) |-> $past(shift_ok)) else $error("illegal shift started");
  a_main_last: assert property (@(posedge clk) disable iff (!rst_n)
    (state == DMS_MAIN) |=> (state == DMS_MAIN || state == DMS_DONE))
    else $error("main cycle not final");
  a_transfer_main: assert property (@(posedge clk) disable iff (!rst_n)
    product_transfer |-> $past(main_cycle)) else $error("transfer outside main cycle");
endmodule // dms_sequencer

// File: test/dms_ctrl_model.sv
// Carriage program control model that drives load, arm and multiply positions.
module dms_ctrl_model
  import dms_pkg::*;
#(
  parameter int ND = DIGITS
) (
  input  wire logic        clk,
  output logic             multiplier_load,
  output logic             multiplicand_load,
  output logic [4*ND-1:0]  operand_in,
  output logic             multiply_arm,
  output logic             multiply_go,
  output logic [3:0]       shift_sel,
  output logic             round_clear
);
  timeunit 1ns;
  timeprecision 1ps;
  initial
  begin
    {multiplier_load, multiplicand_load, multiply_arm, multiply_go} = 4'h0;
    operand_in = '0;
    shift_sel = SHIFT_8;
    round_clear = 1'b0;
  end
  // One position strobes for one clock; the operand bus then shows junk, not the old value.
  task automatic position(input logic [3:0] cmd, input logic [4*ND-1:0] val,
                          input logic [3:0] sh, input logic rc);
    @(posedge clk);
    #1;
    {multiplier_load, multiplicand_load, multiply_arm, multiply_go} = cmd;
    operand_in = val;
    shift_sel = sh;
    round_clear = rc;
    @(posedge clk);
    #1;
    {multiplier_load, multiplicand_load, multiply_arm, multiply_go} = 4'h0;
    operand_in = ~val;
  endtask
endmodule // dms_ctrl_model

// File: test/dms_sequencer_test.sv
// Self-checking bench for the decimal multiply sequencer.
module dms_sequencer_test
  import dms_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int ACC = 4;
  localparam int MAIN = 6;
  logic clk = 1'b0, rst_n = 1'b0, ml, cl, arm, go, rc, busy, serr, add, left, rnd, mn, xfer;
  logic [39:0] opnd, mpv, mcv, mp_keep;
  logic [3:0] sh, dig, pd;
  logic [4:0] col, pc;
  logic pa = 1'b0, pl = 1'b0;
  logic [15:0] lfsr = 16'hd15f;
  logic [3:0] sh_tab[4] = '{SHIFT_8, SHIFT_7, SHIFT_5, SHIFT_2};
  int n_mismatch = 0, checks = 0, n_busy, n_add, n_left, n_round, n_main, n_xfer, n_both;
  int got_q[$], exp_q[$];
  always #2 clk = ~clk;
  dms_sequencer #(.ND(10), .ACC_CLKS(ACC), .MAIN_CLKS(MAIN)) i_dut (.clk(clk), .rst_n(rst_n),
    .multiplier_load(ml), .multiplicand_load(cl), .operand_in(opnd), .multiply_arm(arm),
    .multiply_go(go), .shift_sel(sh), .round_clear(rc), .busy(busy), .shift_error(serr),
    .acc_add(add), .acc_left(left), .acc_digit(dig), .acc_column(col), .acc_round(rnd),
    .main_cycle(mn), .product_transfer(xfer), .multiplier_value(mpv), .multiplicand_value(mcv));
  dms_ctrl_model #(.ND(10)) i_ctl (.clk(clk), .multiplier_load(ml), .multiplicand_load(cl),
    .operand_in(opnd), .multiply_arm(arm), .multiply_go(go), .shift_sel(sh), .round_clear(rc));
  // Slots are logged the cycle after they end, from the digit and column seen in their last cycle, where the late values have settled.
  always @(posedge clk)
  begin
    n_busy += int'(busy);
    n_add += int'(add);
    n_left += int'(add & left);
    n_round += int'(rnd);
    n_main += int'(mn);
    n_xfer += int'(xfer);
    n_both += int'(mn & (add | rnd));
    if (pa && (!add || left != pl))
      got_q.push_back(int'(pd) * 64 + int'(pc) * 2 + int'(pl));
    pa = add;
    pl = left;
    pd = dig;
    pc = col;
  end
  task automatic cmp(input string what, input logic [39:0] e, input logic [39:0] g);
    checks++;
    if (g !== e)
    begin
      n_mismatch++;
      $display("unexpected %s: expected %0h seen %0h", what, e, g);
    end
  endtask
  function automatic logic [39:0] rnd_bcd();
    logic [39:0] v;
    for (int k = 0; k < 10; k++)
    begin
      lfsr = {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
      v[4*k+:4] = 4'(lfsr % 10);
    end
    return v;
  endfunction
  task automatic problem(input logic [39:0] mp, input logic [39:0] mc, input logic [3:0] s,
                         input logic r, input bit load_mp);
    int nz;
    int k;
    int base;
    int exp_busy;
    nz = 0;
    exp_q = {};
    base = s == SHIFT_8 ? LOW_COL_S8 : s == SHIFT_7 ? LOW_COL_S7 :
           s == SHIFT_5 ? LOW_COL_S5 : LOW_COL_S2;
    for (k = 0; k < 10; k++)
      if (mp[4*k+:4] != 4'h0)
      begin
        nz++;
        exp_q.push_back(mp[4*k+:4] * 64 + (base + k) * 2);
        exp_q.push_back(mp[4*k+:4] * 64 + (base + k + 1) * 2 + 1);
      end
    if (load_mp)
      i_ctl.position(4'h8, mp, s, r);
    i_ctl.position(4'h6, mc, s, r);
    {n_busy, n_add, n_left, n_round, n_main, n_xfer, n_both} = '0;
    got_q = {};
    i_ctl.position(4'h1, ~mc, s, r);
    for (k = 0; k < 5000 && busy !== 1'b0; k++)
      @(posedge clk);
    repeat (3) @(posedge clk);
    // One scan clock per digit position plus the closing scan, then the done cycle.
    exp_busy = DIGITS + 1 + 2 * ACC * nz + (r ? 2 * ACC : 0) + MAIN + 1;
    cmp("busy cycles", exp_busy, n_busy);
    cmp("add cycles", 2 * ACC * nz, n_add);
    cmp("left cycles", ACC * nz, n_left);
    cmp("round cycles", r ? 2 * ACC : 0, n_round);
    cmp("main cycles", MAIN, n_main);
    cmp("transfers", 1, n_xfer);
    cmp("overlap", 0, n_both);
    cmp("slot count", exp_q.size(), got_q.size());
    foreach (exp_q[i])
      if (i < got_q.size())
        cmp("slot", exp_q[i], got_q[i]);
    cmp("multiplier", mp, mpv);
    cmp("multiplicand", mc, mcv);
    cmp("shift error", 0, serr);
    $display("problem done, shift %0h", s);
  endtask
  task automatic close_out();
    $display("checks %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  initial
  begin
    repeat (20000) @(posedge clk);
    n_mismatch++;
    close_out();
  end
  initial
  begin
    repeat (2) @(posedge clk);
    #1 rst_n = 1'b1;
    for (int t = 0; t < 4; t++)
    begin
      mp_keep = rnd_bcd();
      problem(mp_keep, rnd_bcd(), sh_tab[t], t[0], 1'b1);
    end
    problem(mp_keep, rnd_bcd(), SHIFT_5, 1'b1, 1'b0);
    problem(40'h0, rnd_bcd(), SHIFT_8, 1'b0, 1'b1);
    i_ctl.position(4'h2, 40'h0, SHIFT_8, 1'b0);
    i_ctl.position(4'h1, 40'h0, 4'h4, 1'b0);
    cmp("bad shift error", 1, serr);
    cmp("bad shift busy", 0, busy);
    $display("bad shift test done");
    close_out();
  end
endmodule // dms_sequencer_test
